// >>> design/iocch_handler.sv
// i/o configuration command handler: decoded commands in, field answers out
// Functional notes
// - store timezone text, echo with ok
// - current span query, channels 1 to 6
// - current span codes 1 and 2 only
// - code 0 reportable, never settable
// - no expansion board: feature not enabled
// - voltage input returns scaled then raw
// - voltage span codes 1 to 4, channels 1-6
// - successful set echoes arguments with ok
// - digital inputs as 16 bits, input 16 msb
// - input map query: index, level
// - bind input to action, fire on level
// - bind output to action 1-34, open/closed
// - output map query: index and state
// - converter output percent, 6 or 12
// - unproduced variable reports zero
// - default converter functions and flow volume
// - list assignments, skip unassigned channels
// - list only variables of present mode
// - relays alike: single open or closed word
// - mixed relays: mask, bit0 relay 1
// - relay set: one relay or all
`default_nettype none
module iocch_handler
  import iocch_pkg::*;
#(
  parameter int N_CONV_FIT = 12  // converters fitted, 6 or 12
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       cmd_valid,
  output logic                            cmd_ready,
  input  wire iocch_cmd_t                 cmd,
  output logic                            rsp_valid,
  input  wire logic                       rsp_ready,
  output iocch_rsp_t                      rsp,
  input  wire logic                       io_board_pin,
  input  wire logic [N_DIN-1:0]           din_pin,
  input  wire logic [N_VIN-1:0][31:0]     vin_eng,
  input  wire logic [N_VIN-1:0][31:0]     vin_raw,
  input  wire logic [N_CONV-1:0][15:0]    dtoa_pct,
  input  wire logic [N_CONV-1:0]          dtoa_avail,
  input  wire logic [N_VAR-1:0]           var_avail_aout,
  input  wire logic [N_DOUT_ACT:0]        var_avail_dout,
  input  wire logic [N_DIN_ACT:0]         var_avail_din,
  input  wire logic [N_DOUT_ACT:1]        action_state,
  output logic [N_DIN_ACT:1]              din_action_pulse,
  output logic [N_DOUT-1:0]               dout_closed,
  output logic [N_RELAY-1:0]              relay_open,
  output logic [8*TEXT_BYTES-1:0]         timezone_text,
  output logic [N_IOUT-1:0][2:0]          iout_span,
  output logic [N_VOUT-1:0][2:0]          vout_span
);
  // ***************************
  // state and storage
  // ***************************
  typedef enum logic [1:0] {S_IDLE, S_LIST} iocch_state_t;
  iocch_state_t          state_q;                // idle or walking a list
  logic [6:0]            cnt_q;                  // list walk position
  iocch_op_t             list_op_q;              // which list is walked
  logic [1:0]            list_kind_q;            // variable list kind
  logic                  rsp_valid_q;            // answer pending
  iocch_rsp_t            rsp_q;                  // answer held
  logic [N_DIN-1:0][4:0] din_idx_q;              // 0 means unassigned
  logic [N_DIN-1:0]      din_lvl_q;              // 1 fires on high
  logic [N_DOUT-1:0][5:0] dout_idx_q;            // 0 means unassigned
  logic [N_DOUT-1:0]     dout_lvl_q;             // 1 closes when active
  logic [N_DIN:0]        sy1_q, sy2_q, sy3_q;    // pin synchroniser
  logic [N_DIN:0]        stab_q;                 // agreed pin levels

  // ***************************
  // pin synchroniser
  // ***************************
  // a change counts only once stages two and three agree
  always_ff @(posedge clk) begin
    sy1_q <= {io_board_pin, din_pin};
    sy2_q <= sy1_q;
    sy3_q <= sy2_q;
    if (rst) begin
      stab_q <= '0;
    end else begin
      stab_q <= (sy2_q & sy3_q) | (stab_q & (sy2_q | sy3_q));
    end
  end
  wire logic [N_DIN-1:0] din_lvl = stab_q[N_DIN-1:0];
  wire logic             board_ok = stab_q[N_DIN];

  // ***************************
  // command decode
  // ***************************
  wire logic       take   = cmd_valid & cmd_ready;
  wire logic [7:0] ch0    = cmd.chan - 8'h01;          // zero based channel
  wire logic       ch_io  = cmd.chan >= 8'h01 && cmd.chan <= 8'(N_IOUT);
  wire logic       ch_vo  = cmd.chan >= 8'h01 && cmd.chan <= 8'(N_VOUT);
  wire logic       ch_vi  = cmd.chan >= 8'h01 && cmd.chan <= 8'(N_VIN);
  wire logic       ch_di  = cmd.chan >= 8'h01 && cmd.chan <= 8'(N_DIN);
  wire logic       ch_do  = cmd.chan >= 8'h01 && cmd.chan <= 8'(N_DOUT);
  wire logic       ch_cv  = cmd.chan >= 8'h01 && cmd.chan <= 8'(N_CONV_FIT);
  wire logic       ch_rl  = cmd.chan <= 8'(N_RELAY);    // 0 selects all
  // code 0 never accepted, only 1 and 2 for current
  wire logic       io_ok  = cmd.index == 8'(IOUT_0_20MA) || cmd.index == 8'(IOUT_4_20MA);
  wire logic       vo_ok  = cmd.index >= 8'(VOUT_0_1V) && cmd.index <= 8'(VOUT_0_5V);
  wire logic       dia_ok = cmd.index >= 8'h01 && cmd.index <= 8'(N_DIN_ACT);
  wire logic       doa_ok = cmd.index >= 8'h01 && cmd.index <= 8'(N_DOUT_ACT);
  // writes only on accepted, in-range sets
  wire logic       wr_io  = take && cmd.op == OP_SET_IOUT && board_ok && ch_io && io_ok;
  wire logic       wr_vo  = take && cmd.op == OP_SET_VOUT && ch_vo && vo_ok;
  wire logic       wr_di  = take && cmd.op == OP_SET_DIN && ch_di && dia_ok;
  wire logic       wr_do  = take && cmd.op == OP_SET_DOUT && ch_do && doa_ok;
  wire logic       wr_rl  = take && cmd.op == OP_SET_RELAY && ch_rl;
  wire logic       wr_tx  = take && cmd.op == OP_SET_TEXT;
  wire logic       rl_same = (&relay_open) | ~(|relay_open);
  // converter function: 1-6 voltage, 7-12 current; 1 and 7 flow volume
  wire logic       cv_cur = ch0 >= 8'h06;
  wire logic [7:0] cv_var = (ch0 == 8'h00 || ch0 == 8'h06) ? VAR_FLOW_VOL : VAR_NONE;
  // variable mask of the kind asked for, from the present mode
  logic [N_VAR-1:0] sel_mask;
  always_comb begin
    unique case (list_kind_q)
      2'h1:    sel_mask = N_VAR'(var_avail_dout);
      2'h2:    sel_mask = N_VAR'(var_avail_din);
      default: sel_mask = var_avail_aout;
    endcase
  end
  // list walk: entry present, limit of the walk
  wire logic [6:0] lim = list_op_q == OP_LIST_DIN  ? 7'(N_DIN) :
                         list_op_q == OP_LIST_DOUT ? 7'(N_DOUT) : 7'(N_VAR);
  wire logic [3:0] c4  = cnt_q[3:0];
  wire logic       hit = list_op_q == OP_LIST_DIN  ? din_idx_q[c4] != 5'h00 :
                         list_op_q == OP_LIST_DOUT ? dout_idx_q[c4] != 6'h00 :
                         sel_mask[cnt_q[5:0]];

  // ***************************
  // single answer builder
  // ***************************
  iocch_rsp_t one;
  always_comb begin
    one        = '0;
    one.op     = cmd.op;
    one.chan   = cmd.chan;
    one.index  = cmd.index;
    one.level  = cmd.level;
    one.text   = cmd.text;
    one.last   = 1'b1;
    one.status = ST_OK;
    unique case (cmd.op)
      OP_SET_TEXT: ;                                             // echo with ok
      OP_GET_TEXT: one.text = timezone_text;
      OP_GET_IOUT: begin
        if (!board_ok) one.status = ST_NOT_EN;
        else if (!ch_io) one.status = ST_ERR;
        else one.index = 8'(iout_span[ch0[2:0]]);
      end
      OP_SET_IOUT: begin
        if (!board_ok) one.status = ST_NOT_EN;
        else if (!(ch_io && io_ok)) one.status = ST_ERR;
      end
      OP_GET_VOUT: begin
        if (!ch_vo) one.status = ST_ERR;
        else one.index = 8'(vout_span[ch0[2:0]]);
      end
      OP_SET_VOUT: if (!(ch_vo && vo_ok)) one.status = ST_ERR;
      OP_GET_VIN: begin
        if (!board_ok) one.status = ST_NOT_EN;
        else if (!ch_vi) one.status = ST_ERR;
        else begin
          one.val_a = vin_eng[ch0[2:0]];                         // scaled first
          one.val_b = vin_raw[ch0[2:0]];                         // raw volts
        end
      end
      OP_GET_DIGIN: one.val_a = {16'h0000, din_lvl};             // input 16 is msb
      OP_GET_DIN: begin
        if (!ch_di) one.status = ST_ERR;
        else begin
          one.index = 8'(din_idx_q[ch0[3:0]]);
          one.level = din_lvl_q[ch0[3:0]];
        end
      end
      OP_SET_DIN:  if (!(ch_di && dia_ok)) one.status = ST_ERR;
      OP_GET_DOUT: begin
        if (!ch_do) one.status = ST_ERR;
        else begin
          one.index = 8'(dout_idx_q[ch0[3:0]]);
          one.level = dout_lvl_q[ch0[3:0]];
        end
      end
      OP_SET_DOUT: if (!(ch_do && doa_ok)) one.status = ST_ERR;
      OP_GET_DTOA: begin
        if (!ch_cv) one.status = ST_ERR;
        else begin
          // unproduced variable reads as zero
          one.val_a = dtoa_avail[ch0[3:0]] ? {16'h0000, dtoa_pct[ch0[3:0]]} : 32'h0;
          one.val_b = {23'h0, cv_cur, cv_var};
        end
      end
      OP_GET_RELAY: begin
        one.level = rl_same & relay_open[0];                     // open or closed word
        one.index = {7'h00, rl_same};                            // 1: single word
        one.val_a = {16'h0000, relay_open};                      // bit 0 is relay 1
      end
      OP_SET_RELAY: if (!ch_rl) one.status = ST_ERR;
      default: one.last = 1'b0;                                  // list header, walk follows
    endcase
  end

  // ***************************
  // list entry builder
  // ***************************
  iocch_rsp_t ent;
  always_comb begin
    ent        = '0;
    ent.op     = list_op_q;
    ent.status = ST_OK;
    ent.chan   = 8'(cnt_q) + 8'h01;
    unique case (list_op_q)
      OP_LIST_DIN: begin
        ent.index = 8'(din_idx_q[c4]);
        ent.level = din_lvl_q[c4];
      end
      OP_LIST_DOUT: begin
        ent.index = 8'(dout_idx_q[c4]);
        ent.level = dout_lvl_q[c4];
      end
      default: begin
        ent.chan  = {6'h00, list_kind_q};
        ent.index = 8'(cnt_q);
      end
    endcase
  end

  // ***************************
  // sequencer
  // ***************************
  assign cmd_ready = state_q == S_IDLE && !rsp_valid_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp       = rsp_q;
  wire logic is_list = cmd.op == OP_LIST_DIN || cmd.op == OP_LIST_DOUT || cmd.op == OP_LIST_VAR;
  wire logic rsp_free = !rsp_valid_q || rsp_ready;
  // one answer per non-list command; lists walk one entry per free slot
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q     <= S_IDLE;
      cnt_q       <= '0;
      list_op_q   <= OP_LIST_DIN;
      list_kind_q <= 2'h0;
      rsp_valid_q <= 1'b0;
      rsp_q       <= '0;
    end else begin
      if (rsp_valid_q && rsp_ready) rsp_valid_q <= 1'b0;
      if (take) begin
        rsp_q       <= one;
        rsp_valid_q <= 1'b1;
        if (is_list) begin
          state_q     <= S_LIST;
          cnt_q       <= '0;
          list_op_q   <= cmd.op;
          list_kind_q <= cmd.chan[1:0];
        end
      end else if (state_q == S_LIST && rsp_free) begin
        if (cnt_q == lim) begin
          rsp_q       <= '{op: list_op_q, status: ST_OK, last: 1'b1, default: '0};
          rsp_valid_q <= 1'b1;
          state_q     <= S_IDLE;
        end else begin
          // unassigned entries skipped without an answer
          if (hit) begin
            rsp_q       <= ent;
            rsp_valid_q <= 1'b1;
          end
          cnt_q <= cnt_q + 7'h01;
        end
      end
    end
  end

  // ***************************
  // configuration store
  // ***************************
  always_ff @(posedge clk) begin
    if (rst) begin
      iout_span     <= {N_IOUT{SPAN_RST}};
      vout_span     <= {N_VOUT{SPAN_RST}};
      din_idx_q     <= '0;
      din_lvl_q     <= '0;
      dout_idx_q    <= '0;
      dout_lvl_q    <= '0;
      relay_open    <= RELAY_OPEN_RST;
      timezone_text <= '0;
    end else begin
      if (wr_io) iout_span[ch0[2:0]] <= cmd.index[2:0];
      if (wr_vo) vout_span[ch0[2:0]] <= cmd.index[2:0];
      if (wr_di) begin
        din_idx_q[ch0[3:0]] <= cmd.index[4:0];
        din_lvl_q[ch0[3:0]] <= cmd.level;
      end
      if (wr_do) begin
        dout_idx_q[ch0[3:0]] <= cmd.index[5:0];
        dout_lvl_q[ch0[3:0]] <= cmd.level;
      end
      if (wr_rl) begin
        // one relay when numbered, else every relay
        if (cmd.chan == 8'h00) relay_open <= {N_RELAY{cmd.level}};
        else relay_open[ch0[3:0]] <= cmd.level;
      end
      if (wr_tx) timezone_text <= cmd.text;
    end
  end

  // ***************************
  // action binding
  // ***************************
  // fire on the transition into the chosen level, one pulse per edge
  logic [N_DIN_ACT:1] fire;
  logic [N_DOUT-1:0]  close_d;
  logic [N_DIN-1:0]   prev_q;
  always_comb begin
    fire    = '0;
    close_d = '0;
    for (int i = 0; i < N_DIN; i++) begin
      if (din_idx_q[i] != 5'h00 && din_lvl[i] == din_lvl_q[i] && prev_q[i] != din_lvl_q[i]) begin
        fire[din_idx_q[i]] = 1'b1;
      end
    end
    for (int k = 0; k < N_DOUT; k++) begin
      // unassigned outputs stay open
      if (dout_idx_q[k] != 6'h00) begin
        close_d[k] = action_state[dout_idx_q[k]] ~^ dout_lvl_q[k];
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q           <= '0;
      din_action_pulse <= '0;
      dout_closed      <= '0;
    end else begin
      prev_q           <= din_lvl;
      din_action_pulse <= fire;
      dout_closed      <= close_d;
    end
  end
endmodule
`default_nettype wire

// >>> design/iocch_pkg.sv
// package of constants and carriers for the i/o configuration command handler
`default_nettype none
package iocch_pkg;
  // ***************************
  // channel and index ranges
  // ***************************
  localparam int N_IOUT     = 6;   // current output channels
  localparam int N_VOUT     = 6;   // voltage output channels
  localparam int N_VIN      = 8;   // analog voltage input channels
  localparam int N_DIN      = 16;  // digital input channels
  localparam int N_DOUT     = 10;  // digital output channels
  localparam int N_DIN_ACT  = 12;  // highest digital input action index
  localparam int N_DOUT_ACT = 34;  // highest digital output action index
  localparam int N_RELAY    = 16;  // relays with a normal logic bit
  localparam int N_CONV     = 12;  // converters fitted at most
  localparam int N_VAR      = 64;  // analog output variable slots
  localparam int TEXT_BYTES = 16;  // timezone text capacity
  // ***************************
  // span codes
  // ***************************
  localparam logic [2:0] SPAN_UNDEF   = 3'h0; // reportable, never settable
  localparam logic [2:0] IOUT_0_20MA  = 3'h1;
  localparam logic [2:0] IOUT_4_20MA  = 3'h2;
  localparam logic [2:0] VOUT_0_1V    = 3'h1;
  localparam logic [2:0] VOUT_0_100MV = 3'h2;
  localparam logic [2:0] VOUT_0_10V   = 3'h3;
  localparam logic [2:0] VOUT_0_5V    = 3'h4;
  // ***************************
  // reset values
  // ***************************
  localparam logic [2:0]  SPAN_RST      = SPAN_UNDEF;
  localparam logic [15:0] RELAY_OPEN_RST = 16'hffff; // all normally open
  localparam logic [7:0]  VAR_FLOW_VOL  = 8'h06;    // flow volume variable
  localparam logic [7:0]  VAR_NONE      = 8'h00;
  // ***************************
  // commands and answers
  // ***************************
  typedef enum logic [4:0] {
    OP_SET_TEXT, OP_GET_TEXT, OP_GET_IOUT, OP_SET_IOUT, OP_GET_VOUT,
    OP_SET_VOUT, OP_GET_VIN, OP_GET_DIGIN, OP_GET_DIN, OP_SET_DIN,
    OP_GET_DOUT, OP_SET_DOUT, OP_GET_DTOA, OP_LIST_DIN, OP_LIST_DOUT,
    OP_LIST_VAR, OP_GET_RELAY, OP_SET_RELAY
  } iocch_op_t;
  typedef enum logic [1:0] {ST_OK, ST_ERR, ST_NOT_EN} iocch_status_t;
  typedef struct packed {
    iocch_op_t               op;
    logic [7:0]              chan;  // channel, relay or list kind
    logic [7:0]              index; // action index or span code
    logic                    level; // high / closed / normally open
    logic [8*TEXT_BYTES-1:0] text;  // timezone text
  } iocch_cmd_t;
  typedef struct packed {
    iocch_op_t               op;
    iocch_status_t           status;
    logic [7:0]              chan;
    logic [7:0]              index;
    logic                    level;
    logic [31:0]             val_a;
    logic [31:0]             val_b;
    logic [8*TEXT_BYTES-1:0] text;
    logic                    last;  // final answer of this command
  } iocch_rsp_t;
endpackage
`default_nettype wire

// >>> verif/iocch_host.sv
// host model: offers decoded commands and takes every answer
`default_nettype none
module iocch_host
  import iocch_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       cmd_ready,
  input  wire logic       rsp_valid,
  input  wire iocch_rsp_t rsp,
  output logic            cmd_valid,
  output iocch_cmd_t      cmd,
  output logic            rsp_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle host at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
    rsp_ready = 1'b0;
  end
  // one command, then answers up to last; slow holds off ready for a while
  task automatic xfer(input iocch_cmd_t c, input int slow, output iocch_rsp_t r0,
                      output int n, output bit ok);
    int t;
    n = 0;
    ok = 1'b0;
    t = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= c;
    do begin
      @(posedge clk);
      t++;
    end while (cmd_ready !== 1'b1 && t < 50);
    // released command lines carry junk, never the old value
    cmd_valid <= 1'b0;
    cmd <= ~c;
    if (t >= 50) return;
    t = 0;
    while (t < 300) begin
      @(posedge clk);
      t++;
      if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
        if (n == 0) r0 = rsp;
        n++;
        if (rsp.last === 1'b1) begin
          ok = 1'b1;
          break;
        end
      end
      rsp_ready <= (rsp_valid === 1'b1 && t > slow);
    end
    rsp_ready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> verif/iocch_handler_asserts.sv
// concurrent checks on the ports of the command handler
`default_nettype none
module iocch_handler_asserts
  import iocch_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    cmd_valid,
  input  wire logic                    cmd_ready,
  input  wire iocch_cmd_t              cmd,
  input  wire logic                    rsp_valid,
  input  wire logic                    rsp_ready,
  input  wire iocch_rsp_t              rsp,
  input  wire logic                    io_board_pin,
  input  wire logic [N_DIN_ACT:1]      din_action_pulse,
  input  wire logic [N_RELAY-1:0]      relay_open,
  input  wire logic [N_IOUT-1:0][2:0]  iout_span,
  input  wire logic [N_VOUT-1:0][2:0]  vout_span
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic take = cmd_valid && cmd_ready; // command accepted this edge
  logic span_bad; // some stored span outside its table
  // both span banks are six wide
  always_comb begin
    span_bad = 1'b0;
    for (int i = 0; i < N_IOUT; i++) begin
      span_bad = span_bad || (iout_span[i] > 3'h2) || (vout_span[i] > 3'h4);
    end
  end
  sequence s_board_gone;
    !io_board_pin [*5];
  endsequence
  sequence s_bad_iout;
    take && cmd.op == OP_SET_IOUT && (cmd.chan == 8'h0 || cmd.chan > 8'h6 ||
      cmd.index == 8'h0 || cmd.index > 8'h2);
  endsequence
  sequence s_relay_one;
    take && cmd.op == OP_SET_RELAY && cmd.chan >= 8'h1 && cmd.chan <= 8'h10;
  endsequence
  chk_answer_next: assert property (take |=> rsp_valid)
    else $error("no answer one cycle after take");
  chk_answer_holds: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp))
    else $error("answer moved before accept");
  chk_busy_refuse: assert property (rsp_valid |-> !cmd_ready)
    else $error("ready while answer pends");
  chk_span_codes: assert property (!span_bad)
    else $error("stored span code outside table");
  chk_bad_keeps: assert property (s_bad_iout |=> $stable(iout_span))
    else $error("bad span set changed store");
  chk_undef_never: assert property (iout_span[0] != 3'h0 |=> iout_span[0] != 3'h0)
    else $error("span returned to undefined");
  chk_relay_one: assert property (s_relay_one |=> ((relay_open ^ $past(relay_open)) &
    ~(16'h1 << ($past(cmd.chan) - 8'h1))) == 16'h0)
    else $error("relay set touched other relays");
  chk_not_enabled: assert property (s_board_gone ##0 (take && (cmd.op == OP_GET_IOUT ||
    cmd.op == OP_GET_VIN)) |=> rsp.status == ST_NOT_EN)
    else $error("board absent but feature answered");
  chk_pulse_short: assert property (|din_action_pulse |=>
    (din_action_pulse & $past(din_action_pulse)) == '0)
    else $error("action pulse longer than one cycle");
  chk_reset_vals: assert property ($fell(rst) |-> relay_open == RELAY_OPEN_RST &&
    iout_span == '0)
    else $error("reset values wrong");
endmodule
bind iocch_handler iocch_handler_asserts i_chk (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp),
  .io_board_pin(io_board_pin), .din_action_pulse(din_action_pulse),
  .relay_open(relay_open), .iout_span(iout_span), .vout_span(vout_span));
`default_nettype wire

// >>> verif/iocch_handler_tb.sv
// self-checking testbench of the command handler
`default_nettype none
module iocch_handler_tb
  import iocch_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ***************************
  // stimulus and observed signals
  // ***************************
  logic                          clk = 1'b0;
  logic                          rst = 1'b1;
  logic                          io_board_pin = 1'b0;
  logic                          cmd_valid, cmd_ready, rsp_valid, rsp_ready;
  iocch_cmd_t                    cmd;
  iocch_rsp_t                    rsp, r;
  logic [N_DIN-1:0]              din_pin = '0;
  logic [N_VIN-1:0][31:0]        vin_eng = '0;
  logic [N_VIN-1:0][31:0]        vin_raw;
  logic [N_CONV-1:0][15:0]       dtoa_pct = '0;
  logic [N_CONV-1:0]             dtoa_avail = '0;
  logic [N_VAR-1:0]              var_avail_aout = 64'h0f;
  logic [N_DOUT_ACT:0]           var_avail_dout = '1;
  logic [N_DIN_ACT:0]            var_avail_din = 13'h0016;   // three actions offered
  logic [N_DOUT_ACT:1]           action_state = '0;
  logic [N_DIN_ACT:1]            din_action_pulse;
  logic [N_DOUT-1:0]             dout_closed;
  logic [N_RELAY-1:0]            relay_open;
  logic [8*TEXT_BYTES-1:0]       timezone_text;
  logic [8*TEXT_BYTES-1:0]       zone = "UTC0";
  logic [N_IOUT-1:0][2:0]        iout_span;
  logic [N_VOUT-1:0][2:0]        vout_span;
  int                            n_mismatch = 0;
  int                            n_compared = 0;
  int                            n;            // answers of the last command
  int                            slow = 0;     // host stall on answers
  always #2.5 clk = ~clk;
  // raw voltages differ per channel so a wrong channel shows
  initial for (int i = 0; i < N_VIN; i++) vin_raw[i] = 32'h100 + i;
  iocch_handler i_dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd(cmd), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp),
    .io_board_pin(io_board_pin), .din_pin(din_pin), .vin_eng(vin_eng), .vin_raw(vin_raw),
    .dtoa_pct(dtoa_pct), .dtoa_avail(dtoa_avail), .var_avail_aout(var_avail_aout),
    .var_avail_dout(var_avail_dout), .var_avail_din(var_avail_din),
    .action_state(action_state), .din_action_pulse(din_action_pulse),
    .dout_closed(dout_closed), .relay_open(relay_open), .timezone_text(timezone_text),
    .iout_span(iout_span), .vout_span(vout_span));
  iocch_host i_host (.clk(clk), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .cmd_valid(cmd_valid), .cmd(cmd), .rsp_ready(rsp_ready));
  // ***************************
  // shared tasks
  // ***************************
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // a hung handshake ends the run as a failure
  task automatic run(input iocch_op_t op, input int ch, idx, lv);
    iocch_cmd_t c;
    bit ok;
    c = '0;
    c.op = op;
    c.chan = ch[7:0];
    c.index = idx[7:0];
    c.level = lv[0];
    c.text = zone;
    i_host.xfer(c, slow, r, n, ok);
    if (!ok) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  task automatic set_one(input iocch_op_t op, input int ch, idx, lv, input bit ok);
    run(op, ch, idx, lv);
    chk("set status", r.status, ok ? ST_OK : ST_ERR);
    if (ok) chk("set echo", {r.chan, r.index, r.level}, {ch[7:0], idx[7:0], lv[0]});
  endtask
  // ***************************
  // scenarios
  // ***************************
  task automatic t_absent();
    chk("relay reset", relay_open, RELAY_OPEN_RST);
    chk("span reset", {iout_span, vout_span}, '0);
    repeat (8) @(posedge clk);
    run(OP_GET_IOUT, 1, 0, 0);
    chk("iout absent", r.status, ST_NOT_EN);
    run(OP_GET_VIN, 1, 0, 0);
    chk("vin absent", r.status, ST_NOT_EN);
    io_board_pin <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic t_spans();
    logic [N_IOUT-1:0][2:0] ei;
    logic [N_VOUT-1:0][2:0] ev;
    int tab[7][3] = '{'{1,1,1}, '{6,2,1}, '{0,1,0}, '{7,1,0}, '{2,0,0}, '{3,3,0}, '{4,1,1}};
    ei = '0;
    ev = '0;
    for (int i = 0; i < 7; i++) begin
      set_one(OP_SET_IOUT, tab[i][0], tab[i][1], 0, tab[i][2] == 1);
      if (tab[i][2] == 1) ei[tab[i][0] - 1] = 3'(tab[i][1]);
    end
    // codes 5 down to 0 over channels 1 to 6, then channel 7
    for (int k = 1; k <= 7; k++) begin
      set_one(OP_SET_VOUT, k, (6 - k) & 8'hff, 0, k <= 6 && k >= 2 && k <= 5);
      if (k >= 2 && k <= 5) ev[k - 1] = 3'(6 - k);
    end
    chk("iout store", iout_span, ei);
    chk("vout store", vout_span, ev);
    run(OP_GET_IOUT, 6, 0, 0);
    chk("iout get 6", r.index, 8'h2);
    run(OP_GET_IOUT, 2, 0, 0);
    chk("iout undefined", r.index, 8'h0);
    run(OP_GET_VOUT, 2, 0, 0);
    chk("vout get 2", r.index, 8'h4);
  endtask
  task automatic t_text_inputs();
    run(OP_SET_TEXT, 0, 0, 0);
    chk("text store", timezone_text, zone);
    run(OP_GET_TEXT, 0, 0, 0);
    chk("text get", r.text, zone);
    din_pin <= 16'h8001;
    vin_eng[2] <= 32'h0bad_cafe;
    repeat (6) @(posedge clk);
    run(OP_GET_DIGIN, 0, 0, 0);
    chk("dig in", r.val_a[15:0], 16'h8001);
    run(OP_GET_VIN, 3, 0, 0);
    chk("vin pair", {r.val_a, r.val_b}, {32'h0bad_cafe, 32'h102});
  endtask
  task automatic t_din_dout();
    int hits;
    hits = 0;
    set_one(OP_SET_DIN, 5, 3, 1, 1);
    set_one(OP_SET_DIN, 17, 3, 1, 0);
    set_one(OP_SET_DIN, 5, 13, 1, 0);
    run(OP_GET_DIN, 5, 0, 0);
    chk("din map", {r.index, r.level}, {8'h3, 1'b1});
    din_pin <= 16'h8011;
    for (int t = 0; t < 12; t++) begin
      @(posedge clk);
      if (din_action_pulse === 12'h004) hits++;
    end
    din_pin <= 16'h8001;
    repeat (12) @(posedge clk);
    chk("din pulses", hits, 1);
    set_one(OP_SET_DOUT, 4, 11, 1, 1);
    set_one(OP_SET_DOUT, 11, 11, 1, 0);
    set_one(OP_SET_DOUT, 4, 35, 0, 0);
    run(OP_GET_DOUT, 4, 0, 0);
    chk("dout map", {r.index, r.level}, {8'd11, 1'b1});
    action_state[11] <= 1'b1;
    repeat (3) @(posedge clk);
    chk("dout active", dout_closed, 10'h008);
    action_state[11] <= 1'b0;
    repeat (3) @(posedge clk);
    chk("dout idle", dout_closed, 10'h000);
  endtask
  task automatic t_dtoa_relay();
    dtoa_pct[6] <= 16'h03d1;
    dtoa_pct[0] <= 16'h0777;
    dtoa_avail <= 12'h040;
    run(OP_GET_DTOA, 7, 0, 0);
    chk("dtoa 7", {r.val_a, r.val_b[8:0]}, {32'h3d1, 9'h106});
    run(OP_GET_DTOA, 1, 0, 0);
    chk("dtoa 1", {r.val_a, r.val_b[8:0]}, {32'h0, 9'h006});
    run(OP_GET_DTOA, 2, 0, 0);
    chk("dtoa 2", r.val_b[8:0], 9'h000);
    run(OP_GET_RELAY, 0, 0, 0);
    chk("relay alike", {r.index, r.level}, {8'h1, 1'b1});
    set_one(OP_SET_RELAY, 3, 0, 0, 1);
    set_one(OP_SET_RELAY, 17, 0, 0, 0);
    chk("relay one", relay_open, 16'hfffb);
    run(OP_GET_RELAY, 0, 0, 0);
    chk("relay mixed", {r.index, r.val_a[15:0]}, {8'h0, 16'hfffb});
    set_one(OP_SET_RELAY, 0, 0, 0, 1);
    run(OP_GET_RELAY, 0, 0, 0);
    chk("relay closed", {r.index, r.level, relay_open}, {8'h1, 1'b0, 16'h0});
  endtask
  task automatic t_lists();
    slow = 3;
    run(OP_LIST_DIN, 0, 0, 0);
    chk("list din", n, 3);
    run(OP_LIST_DOUT, 0, 0, 0);
    chk("list dout", n, 3);
    run(OP_LIST_VAR, 2, 0, 0);
    chk("list var din", n, 5);
    run(OP_LIST_VAR, 0, 0, 0);
    chk("list var aout", n, 6);
  endtask
  // ***************************
  // main sequence
  // ***************************
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_absent();
    t_spans();
    t_text_inputs();
    t_din_dout();
    t_dtoa_relay();
    t_lists();
    report_and_stop();
  end
endmodule
`default_nettype wire
